// ===== logic/eecm_ctrl.sv
// eeprom command controller: mode handling, buffer, flags, apb slave
// assumes apb master in pclk domain; mode inputs synchronous to pclk
`timescale 1ns/1ps
module eecm_ctrl
    import eecm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [22:0] gaddr,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        background_debug_state,
    input  wire logic        secured,
    input  wire logic        special_single_chip,
    output logic             array_sel,
    output logic [10:0]      array_addr,
    output logic             hv_on,
    output logic             wake_req
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic        command_complete_flag;
    logic        command_buffer_empty_flag_q, command_buffer_empty_flag_d;
    logic        acc_q, acc_d;
    logic        pviol_q, pviol_d;
    logic [7:0]  array_protection_register;
    logic [7:0]  prot_q, prot_d;
    logic        prot_lock_q, prot_lock_d;
    logic [1:0]  ie_q, ie_d;
    logic [10:0] addr_q, addr_d;
    eecm_cmd_t   buf_q, buf_d, act_q, act_d;
    logic        bufv_q, bufv_d;
    eecm_state_t st_q, st_d;
    logic        stop_q;
    logic [31:0] rdata_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic in_upper(input logic [10:0] a, input logic [7:0] p);
        in_upper = p[EECM_B_PEN] && (a >= EECM_PROT_BASE);
    endfunction : in_upper

    wire wr_acc   = psel && penable && pwrite;
    wire rd_acc   = psel && !pwrite;
    wire sel_stat = paddr == EECM_OFS_STAT;
    wire sel_prot = paddr == EECM_OFS_PROT;
    wire sel_addr = paddr == EECM_OFS_ADDR;
    wire sel_cmd  = paddr == EECM_OFS_CMD;
    wire sel_ctrl = paddr == EECM_OFS_CTRL;
    wire mapped   = sel_stat | sel_prot | sel_addr | sel_cmd | sel_ctrl;

    assign array_sel  = (gaddr >= EECM_WIN_LO) && (gaddr <= EECM_WIN_HI);
    assign array_addr = gaddr[EECM_AW-1:0];
    assign array_protection_register = prot_q;

    wire [7:0] cmd_w   = pwdata[7:0];
    wire known_cmd     = (cmd_w == EECM_CMD_PROG) || (cmd_w == EECM_CMD_SERA)
                      || (cmd_w == EECM_CMD_MERA) || (cmd_w == EECM_CMD_SMOD);
    wire restricted    = background_debug_state && secured && special_single_chip;
    wire cmd_allowed   = known_cmd && (!restricted || cmd_w == EECM_CMD_MERA);
    wire cmd_prot      = (cmd_w != EECM_CMD_MERA) && in_upper(addr_q, prot_q)
                      || (cmd_w == EECM_CMD_MERA) && prot_q[EECM_B_PEN];
    wire cmd_wr        = wr_acc && sel_cmd;
    // sequence refused while error is pending
    wire cmd_ok        = cmd_wr && command_buffer_empty_flag_q && !acc_q && cmd_allowed && !cmd_prot;
    wire cmd_bad       = cmd_wr && !cmd_ok;
    wire stop_enter    = stop_mode && !stop_q;
    wire stop_exit     = !stop_mode && stop_q;
    wire abort         = stop_enter && (st_q == EECM_RUN);
    wire op_done;
    wire op_start;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    // commands keep running in wait mode, so wait_mode gates nothing here
    always_comb begin
        st_d   = st_q;
        act_d  = act_q;
        buf_d  = buf_q;
        bufv_d = bufv_q;
        unique case (st_q)
            EECM_IDLE: begin
                // stop_q guard: nothing launches in the stop exit cycle
                if (bufv_q && !stop_mode && !stop_q) begin
                    act_d  = buf_q;
                    bufv_d = 1'b0;
                    st_d   = EECM_RUN;
                end
            end
            EECM_RUN: begin
                if (abort) begin
                    st_d = EECM_IDLE;
                end else if (op_done) begin
                    if (bufv_q) begin
                        act_d  = buf_q;
                        bufv_d = 1'b0;
                    end else begin
                        st_d = EECM_IDLE;
                    end
                end
            end
        endcase
        if (cmd_ok) begin
            buf_d  = '{cmd: cmd_w, addr: addr_q};
            bufv_d = 1'b1;
        end
        // abort drops the queued command too, so complete can rise while stopped
        if (abort) bufv_d = 1'b0;
        if (stop_exit) bufv_d = 1'b0;
    end
    assign op_start = (st_q == EECM_IDLE && st_d == EECM_RUN)
                   || (st_q == EECM_RUN && op_done && bufv_q && !abort);

    eecm_hv u_hv (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (op_start),
        .abort   (stop_enter),
        .hv_on   (hv_on),
        .done    (op_done)
    );

    // ------------------------------------------------------------
    // flags and registers
    // ------------------------------------------------------------
    assign command_complete_flag = (st_q == EECM_IDLE) && !bufv_q;

    always_comb begin
        command_buffer_empty_flag_d     = command_buffer_empty_flag_q;
        acc_d       = acc_q;
        pviol_d     = pviol_q;
        prot_d      = prot_q;
        prot_lock_d = prot_lock_q;
        ie_d        = ie_q;
        addr_d      = addr_q;
        if (wr_acc && sel_stat) begin
            if (pwdata[EECM_B_ACC]) acc_d = 1'b0;
            if (pwdata[EECM_B_PV])  pviol_d = 1'b0;
        end
        // protection writable once, or any time under debug
        if (wr_acc && sel_prot && (!prot_lock_q || background_debug_state)) begin
            prot_d      = pwdata[7:0];
            prot_lock_d = 1'b1;
        end
        if (wr_acc && sel_addr) addr_d = pwdata[EECM_AW-1:0];
        if (wr_acc && sel_ctrl) ie_d = pwdata[1:0];
        // set wins over clear
        if (cmd_bad && command_buffer_empty_flag_q && !acc_q && !cmd_allowed) acc_d = 1'b1;
        if (cmd_bad && command_buffer_empty_flag_q && !acc_q && cmd_allowed)  pviol_d = 1'b1;
        if (abort) acc_d = 1'b1;
        if (cmd_ok) command_buffer_empty_flag_d = 1'b0;
        if (st_q == EECM_IDLE && bufv_q && !stop_mode && !stop_q) command_buffer_empty_flag_d = 1'b1;
        if (st_q == EECM_RUN && op_done && bufv_q) command_buffer_empty_flag_d = 1'b1;
        if (stop_exit) command_buffer_empty_flag_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q        <= EECM_IDLE;
            act_q       <= '0;
            buf_q       <= '0;
            bufv_q      <= 1'b0;
            command_buffer_empty_flag_q     <= 1'b1;
            acc_q       <= 1'b0;
            pviol_q     <= 1'b0;
            prot_q      <= 8'h00;
            prot_lock_q <= 1'b0;
            ie_q        <= 2'h0;
            addr_q      <= 11'h000;
            stop_q      <= 1'b0;
        end else begin
            st_q        <= st_d;
            act_q       <= act_d;
            buf_q       <= buf_d;
            bufv_q      <= bufv_d;
            command_buffer_empty_flag_q     <= command_buffer_empty_flag_d;
            acc_q       <= acc_d;
            pviol_q     <= pviol_d;
            prot_q      <= prot_d;
            prot_lock_q <= prot_lock_d;
            ie_q        <= ie_d;
            addr_q      <= addr_d;
            stop_q      <= stop_mode;
        end
    end

    // wake, raised in wait mode only, also serves as interrupt request; no separate irq logic
    assign wake_req = wait_mode && ((ie_q[0] && command_complete_flag)
                    || (ie_q[1] && command_buffer_empty_flag_q));

    // ------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------
    wire [31:0] stat_w = {27'h0, hv_on, pviol_q, acc_q, command_buffer_empty_flag_q, command_complete_flag};
    wire [31:0] rd_mux = sel_stat ? stat_w
                       : sel_prot ? {24'h0, array_protection_register}
                       : sel_addr ? {21'h0, addr_q}
                       : sel_cmd  ? {24'h0, act_q.cmd}
                       : sel_ctrl ? {30'h0, ie_q} : 32'h0;

    // latched in setup so prdata is settled well before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rdata_q <= 32'h0;
        else if (rd_acc && !penable) rdata_q <= rd_mux;
    end
    assign prdata  = rdata_q;
    // zero wait states: every register answers in the access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_command_complete_flag_busy   : assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == EECM_RUN) |-> !command_complete_flag) else $error("command_complete_flag high while busy");
    a_stop_abort  : assert property (@(posedge pclk) disable iff (!presetn)
        abort |=> acc_q && command_complete_flag && !hv_on) else $error("stop abort wrong");
    a_stop_exit   : assert property (@(posedge pclk) disable iff (!presetn)
        stop_exit && !cmd_ok |=> command_buffer_empty_flag_q && !bufv_q) else $error("buffer kept over stop");
    a_win_decode  : assert property (@(posedge pclk) disable iff (!presetn)
        array_sel |-> gaddr[22:11] == EECM_WIN_LO[22:11]) else $error("window decode");
    a_prot_refuse : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && cmd_w == EECM_CMD_PROG && in_upper(addr_q, prot_q) |=> !bufv_q || $past(bufv_q))
        else $error("protected command accepted");
    a_acc_block   : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && acc_q |=> $stable(buf_q)) else $error("command taken with error");
    a_secure_only : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_ok && restricted |-> cmd_w == EECM_CMD_MERA) else $error("secured non mass erase");
    a_prot_debug  : assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && sel_prot && background_debug_state |=> prot_q == $past(pwdata[7:0]))
        else $error("debug prot write lost");
    a_wait_chain  : assert property (@(posedge pclk) disable iff (!presetn)
        st_q == EECM_RUN && op_done && bufv_q && !abort |=> st_q == EECM_RUN) else $error("buffered dropped");
    a_wake        : assert property (@(posedge pclk) disable iff (!presetn)
        wait_mode && ie_q[0] && command_complete_flag |-> wake_req) else $error("no wake");

    a_command_buffer_empty_flag_buf   : assert property (@(posedge pclk) disable iff (!presetn)
        bufv_q |-> !command_buffer_empty_flag_q)
        else $error("buffer full but empty flag set");
    a_hv_idle     : assert property (@(posedge pclk) disable iff (!presetn)
        st_q == EECM_IDLE |-> !hv_on)
        else $error("high voltage on while idle");
    a_stop_launch : assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode || stop_q |-> !op_start)
        else $error("command launched around stop");
    a_command_complete_flag_done   : assert property (@(posedge pclk) disable iff (!presetn)
        st_q == EECM_RUN && op_done && !bufv_q && !cmd_ok |=> command_complete_flag)
        else $error("complete flag not raised");
    a_cmd_queue   : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_ok && !abort && !stop_exit |=> bufv_q && !command_buffer_empty_flag_q)
        else $error("accepted command not buffered");
    a_prot_lock   : assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && sel_prot && prot_lock_q && !background_debug_state |=> $stable(prot_q))
        else $error("locked protection changed");
    a_acc_refuse  : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_bad && command_buffer_empty_flag_q && !acc_q && !cmd_allowed |=> acc_q)
        else $error("refused command without error");
    a_pviol_set   : assert property (@(posedge pclk) disable iff (!presetn)
        cmd_bad && command_buffer_empty_flag_q && !acc_q && cmd_allowed |=> pviol_q)
        else $error("protected target without violation");
    a_wait_run    : assert property (@(posedge pclk) disable iff (!presetn)
        wait_mode && st_q == EECM_RUN && !abort && !op_done |=> st_q == EECM_RUN)
        else $error("command dropped in wait");
    a_abort_drop  : assert property (@(posedge pclk) disable iff (!presetn)
        abort |=> !bufv_q && !hv_on)
        else $error("abort left work pending");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    c_cmd_run   : cover property (@(posedge pclk) disable iff (!presetn) op_start);
    c_stop_abort: cover property (@(posedge pclk) disable iff (!presetn) abort);
    c_chain     : cover property (@(posedge pclk) disable iff (!presetn) op_done && bufv_q);
    c_wake      : cover property (@(posedge pclk) disable iff (!presetn) wake_req);
    c_stop_exit : cover property (@(posedge pclk) disable iff (!presetn) stop_exit);
endmodule : eecm_ctrl

// ===== logic/eecm_pkg.sv
// package for the eeprom command mode controller
// assumes a single pclk domain and an apb register port
package eecm_pkg;

    localparam logic [22:0] EECM_WIN_LO    = 23'h13F800;
    localparam logic [22:0] EECM_WIN_HI    = 23'h13FFFF;
    localparam int          EECM_AW        = 11;

    // register byte offsets
    localparam logic [7:0]  EECM_OFS_STAT  = 8'h00;
    localparam logic [7:0]  EECM_OFS_PROT  = 8'h04;
    localparam logic [7:0]  EECM_OFS_ADDR  = 8'h08;
    localparam logic [7:0]  EECM_OFS_CMD   = 8'h0C;
    localparam logic [7:0]  EECM_OFS_CTRL  = 8'h10;

    // status bits
    localparam int EECM_B_COMMAND_COMPLETE_FLAG  = 0;
    localparam int EECM_B_COMMAND_BUFFER_EMPTY_FLAG = 1;
    localparam int EECM_B_ACC   = 2;
    localparam int EECM_B_PV    = 3;
    localparam int EECM_B_HV    = 4;

    // protection register fields
    localparam int          EECM_B_PEN     = 7;
    localparam logic [10:0] EECM_PROT_BASE = 11'h600;

    localparam logic [7:0]  EECM_CMD_PROG  = 8'h20;
    localparam logic [7:0]  EECM_CMD_SERA  = 8'h40;
    localparam logic [7:0]  EECM_CMD_MERA  = 8'h41;
    localparam logic [7:0]  EECM_CMD_SMOD  = 8'h60;

    localparam int          EECM_OP_NS     = 400;
    localparam int          EECM_CLK_NS    = 10;
    localparam logic [15:0] EECM_OP_CYC    = 16'((EECM_OP_NS + EECM_CLK_NS - 1) / EECM_CLK_NS);

    typedef struct packed {
        logic [7:0]          cmd;
        logic [EECM_AW-1:0]  addr;
    } eecm_cmd_t;

    typedef enum logic [1:0] {EECM_IDLE, EECM_RUN} eecm_state_t;

endpackage : eecm_pkg

// ===== logic/eecm_hv.sv
// high voltage enable and operation timer for the array
// assumes start and abort come from the command sequencer
`timescale 1ns/1ps
module eecm_hv
    import eecm_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    input  wire logic abort,
    output logic      hv_on,
    output logic      done
);
    logic [15:0] cnt_q;
    logic        on_q;

    // abort beats start so stop kills supply that very edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            on_q  <= 1'b0;
        end else if (abort) begin
            on_q  <= 1'b0;
            cnt_q <= 16'h0000;
        end else if (start) begin
            on_q  <= 1'b1;
            cnt_q <= EECM_OP_CYC;
        end else if (on_q) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) on_q <= 1'b0;
        end
    end
    assign hv_on = on_q;
    assign done  = on_q && (cnt_q == 16'h0001) && !abort;

    a_hv_abort_off : assert property (@(posedge pclk) disable iff (!presetn)
        abort |=> !hv_on) else $error("hv stayed on after abort");
endmodule : eecm_hv

// ===== tb/eecm_cpu.sv
// apb master standing in for the processor core
// assumes one pclk domain; the slave may stretch pready
`timescale 1ns/1ps
module eecm_cpu (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             hung,
    output logic             err_q
);
    initial begin
        {psel, penable, pwrite, hung, err_q} = '0;
        paddr  = '0;
        pwdata = '0;
    end
    // ---------------------------------------------
    // one transfer, idle cycle in front of setup
    // ---------------------------------------------
    // request stands until pready is seen, for up to 64 cycles and then hung is set, so a slow slave is fine
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung    <= (pready !== 1'b1);
        r       = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : eecm_cpu

// ===== tb/tb_eecm_ctrl.sv
// bench for the eeprom command mode controller
// assumes the cpu model owns the apb port; mode pins come from here
`timescale 1ns/1ps
module tb_eecm_ctrl
    import eecm_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, err_q;
    logic        wait_mode, stop_mode, background_debug_state, secured, special_single_chip;
    logic        array_sel, hv_on, wake_req, hv_seen;
    logic [7:0]  paddr;
    logic [10:0] array_addr;
    logic [22:0] gaddr;
    logic [31:0] pwdata, prdata, seen, exp_q[$], msk_q[$];
    logic [7:0]  ops[4] = '{EECM_CMD_PROG, EECM_CMD_SERA, EECM_CMD_SMOD, EECM_CMD_MERA};
    logic [22:0] win[4] = '{EECM_WIN_LO - 23'h1, EECM_WIN_LO, EECM_WIN_HI,
                            EECM_WIN_HI + 23'h1};
    int          fails, comparisons, seed, n;
    event        got;

    eecm_ctrl eecm_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .gaddr, .wait_mode, .stop_mode, .background_debug_state, .secured,
        .special_single_chip, .array_sel, .array_addr, .hv_on, .wake_req);
    eecm_cpu eecm_cpu_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .hung, .err_q);

    // ---------------------------------------------
    // clock, watchdogs, result monitor
    // ---------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge hung) begin
        fails++;
        results();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        results();
    end
    initial forever begin
        @(got);
        chk(seen & msk_q.pop_front(), exp_q.pop_front(), "status read");
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        eecm_cpu_i.xfer(1'b1, a, d, r);
    endtask : wr
    // expectation is queued before the read goes out
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        eecm_cpu_i.xfer(1'b0, a, 32'h0, seen);
        ->got;
    endtask : rdx
    task automatic cmd(input logic [10:0] a, input logic [7:0] c);
        wr(EECM_OFS_ADDR, {21'h0, a});
        wr(EECM_OFS_CMD, {24'h0, c});
    endtask : cmd
    task automatic idle_wait();
        logic [31:0] r;
        r = '0;
        for (int k = 0; k < 200 && r[1:0] !== 2'b11; k++)
            eecm_cpu_i.xfer(1'b0, EECM_OFS_STAT, 32'h0, r);
        chk(32'(r[1:0]), 32'h3, "idle");
        if (r[1:0] !== 2'b11) results();
    endtask : idle_wait
    task automatic results();
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        seed = 41126;
        {presetn, wait_mode, stop_mode, background_debug_state, secured, special_single_chip} = '0;
        gaddr = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdx(EECM_OFS_STAT, 32'h3, 32'h1F);
        foreach (win[i]) begin
            @(posedge pclk);
            gaddr <= win[i];
            @(negedge pclk);
            chk(32'(array_sel), 32'(i == 1 || i == 2), "sel");
            chk(32'(array_addr), 32'(win[i][10:0]), "offset");
        end
        eecm_cpu_i.xfer(1'b0, 8'h40, 32'h0, seen);
        chk(32'(err_q), 32'h1, "unmapped");
        wr(EECM_OFS_CTRL, 32'h1);
        cmd(11'($random(seed)) & 11'h5FF, EECM_CMD_PROG);
        rdx(EECM_OFS_STAT, 32'h0, 32'h1);
        chk(32'(hv_on), 32'h1, "hv run");
        cmd(11'h20, EECM_CMD_SERA);
        rdx(EECM_OFS_STAT, 32'h0, 32'h3);
        wait_mode <= 1'b1;
        for (n = 0; n < 300 && wake_req !== 1'b1; n++) @(negedge pclk);
        chk(32'(n > 50 && n < 300), 32'h1, "wait drain");
        if (n >= 300) results();
        wr(EECM_OFS_CTRL, 32'h0);
        @(negedge pclk);
        chk(32'(wake_req), 32'h0, "wake masked");
        @(posedge pclk);
        wait_mode <= 1'b0;
        cmd(11'h30, EECM_CMD_SMOD);
        repeat (5) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(hv_on), 32'h0, "hv cut");
        stop_mode <= 1'b0;
        rdx(EECM_OFS_STAT, 32'h7, 32'hF);
        cmd(11'h40, EECM_CMD_PROG);
        rdx(EECM_OFS_STAT, 32'h7, 32'h1F);
        wr(EECM_OFS_STAT, 32'h4);
        cmd(11'h50, EECM_CMD_PROG);
        cmd(11'h60, EECM_CMD_PROG);
        stop_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        stop_mode <= 1'b0;
        hv_seen = 1'b0;
        repeat (60) begin
            @(negedge pclk);
            hv_seen |= hv_on;
        end
        chk(32'(hv_seen), 32'h0, "no launch");
        rdx(EECM_OFS_STAT, 32'h7, 32'hF);
        wr(EECM_OFS_STAT, 32'h4);
        wr(EECM_OFS_PROT, 32'h80);
        cmd(11'h600 | (11'($random(seed)) & 11'h1FF), EECM_CMD_PROG);
        rdx(EECM_OFS_STAT, 32'hB, 32'h1B);
        wr(EECM_OFS_STAT, 32'h8);
        cmd(11'h5FF, EECM_CMD_PROG);
        rdx(EECM_OFS_STAT, 32'h0, 32'h9);
        idle_wait();
        wr(EECM_OFS_PROT, 32'h0);
        rdx(EECM_OFS_PROT, 32'h80, 32'h80);
        background_debug_state <= 1'b1;
        special_single_chip    <= 1'b1;
        wr(EECM_OFS_PROT, 32'h0);
        rdx(EECM_OFS_PROT, 32'h0, 32'h80);
        for (int s = 1; s >= 0; s--) begin
            secured <= 1'(s);
            foreach (ops[i]) begin
                cmd(11'h70, ops[i]);
                n = (s == 1 && ops[i] != EECM_CMD_MERA) ? 5 : 0;
                rdx(EECM_OFS_STAT, 32'(n), 32'h5);
                wr(EECM_OFS_STAT, 32'h4);
                idle_wait();
            end
        end
        results();
    end
endmodule : tb_eecm_ctrl
